// ---- design/iobc_pkg.sv ----
// package of constants and types for the i/o bus command cycles
package iobc_pkg;
  localparam int BUS_W = 24;
  localparam int BASIC_HI = 23;
  localparam int BASIC_LO = 20;
  localparam int CHAN_HI = 19;
  localparam int CHAN_LO = 16;
  localparam int SUB_HI = 3;
  localparam int SUB_LO = 0;
  localparam int DATA_HI = 15;
  localparam int STAT_LO = 16;
  localparam int REVERSE_BIT = 21;
  localparam int ID_LO = 1;
  localparam logic [3:0] BASIC_SUBCMD = 4'h1;
  localparam logic [3:0] BASIC_XOUT_A = 4'h2;
  localparam logic [3:0] BASIC_XOUT_B = 4'h3;
  localparam logic [3:0] BASIC_XIN = 4'h4;
  localparam logic [3:0] SUB_TEST = 4'h1;
  localparam logic [3:0] SUB_CLEAR = 4'h3;
  localparam logic [3:0] SUB_SERVICE = 4'h5;
  localparam logic [3:0] SUB_TERMINATE = 4'h6;
  localparam logic [4:0] STATUS_RESET = 5'h00;
  localparam int FIFO_DEPTH = 32;
  typedef enum logic [2:0]
  {
    IOBC_NONE = 3'b000,
    IOBC_XOUT_A = 3'b001,
    IOBC_XOUT_B = 3'b010,
    IOBC_XIN = 3'b011,
    IOBC_TEST = 3'b100,
    IOBC_CLEAR = 3'b101,
    IOBC_SERVICE = 3'b110,
    IOBC_TERM = 3'b111
  } iobc_cmd_t;
  function automatic iobc_cmd_t iobc_decode(input logic [23:0] w);
    iobc_cmd_t c;
    c = IOBC_NONE;
    if (w[BASIC_HI:BASIC_LO] == BASIC_XOUT_A)
      c = IOBC_XOUT_A;
    else if (w[BASIC_HI:BASIC_LO] == BASIC_XOUT_B)
      c = IOBC_XOUT_B;
    else if (w[BASIC_HI:BASIC_LO] == BASIC_XIN)
      c = IOBC_XIN;
    else if (w[BASIC_HI:BASIC_LO] == BASIC_SUBCMD)
    begin
      if (w[SUB_HI:SUB_LO] == SUB_TEST)
        c = IOBC_TEST;
      else if (w[SUB_HI:SUB_LO] == SUB_CLEAR)
        c = IOBC_CLEAR;
      else if (w[SUB_HI:SUB_LO] == SUB_SERVICE)
        c = IOBC_SERVICE;
      else if (w[SUB_HI:SUB_LO] == SUB_TERMINATE)
        c = IOBC_TERM;
    end
    return c;
  endfunction : iobc_decode
endpackage : iobc_pkg

// ---- design/iobc_if.sv ----
// interface joining the processor end and one control end
`timescale 1ns/1ns
`default_nettype none
interface iobc_if;
  logic command_active_strobe;
  logic response_complete_strobe;
  logic [23:0] host_bus;
  logic host_bus_oe;
  logic [23:0] ctl_bus;
  logic ctl_bus_oe;
  logic [23:0] bus_level;
  assign bus_level = ctl_bus_oe ? ctl_bus : (host_bus_oe ? host_bus : 24'h000000);
  modport host (output command_active_strobe, output response_complete_strobe,
    output host_bus, output host_bus_oe, input bus_level);
  modport ctl (input command_active_strobe, input response_complete_strobe,
    output ctl_bus, output ctl_bus_oe, input bus_level);
endinterface : iobc_if
`default_nettype wire

// ---- design/iobc_fifo.sv ----
// parameterised flip-flop fifo with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none
module iobc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;
  assign in_ready_o = (count_reg != (AW + 1)'(DEPTH));
  assign out_valid_o = (count_reg != '0);
  assign out_data_o = mem_reg[rd_reg];
  assign push = clk_en_i && in_valid_i && in_ready_o;
  assign pop = clk_en_i && out_valid_o && out_ready_i;
  always_ff @(posedge core_clk_i)
  begin
    if (push)
      mem_reg[wr_reg] <= in_data_i;
  end
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      wr_reg <= '0;
      rd_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (push)
        wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
      if (pop)
        rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
      if (push && !pop)
        count_reg <= count_reg + 1'b1;
      else if (pop && !push)
        count_reg <= count_reg - 1'b1;
    end
  end
endmodule : iobc_fifo
`default_nettype wire

// ---- design/iobc_host.sv ----
// processor end: runs one two-phase command cycle per request
`timescale 1ns/1ns
`default_nettype none
module iobc_host (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  iobc_if.host bus,
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire logic [23:0] req_word_i,
  input wire logic req_data_phase_b_i,
  output logic resp_valid_o,
  output logic [23:0] resp_word_o
);
  typedef enum logic [1:0]
  {
    IOBC_H_IDLE = 2'b00,
    IOBC_H_GAP = 2'b01,
    IOBC_H_PHB = 2'b10,
    IOBC_H_DONE = 2'b11
  } iobc_hstate_t;
  iobc_hstate_t state_reg;
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_reg <= IOBC_H_IDLE;
      bus.command_active_strobe <= 1'b0;
      bus.response_complete_strobe <= 1'b0;
      bus.host_bus <= 24'h000000;
      bus.host_bus_oe <= 1'b0;
      req_ready_o <= 1'b0;
      resp_valid_o <= 1'b0;
      resp_word_o <= 24'h000000;
    end
    else if (clk_en_i)
    begin
      bus.command_active_strobe <= 1'b0;
      bus.response_complete_strobe <= 1'b0;
      resp_valid_o <= 1'b0;
      req_ready_o <= 1'b0;
      case (state_reg)
        IOBC_H_IDLE:
        begin
          if (req_valid_i)
          begin
            bus.command_active_strobe <= 1'b1;
            bus.host_bus <= req_word_i;
            bus.host_bus_oe <= 1'b1;
            req_ready_o <= 1'b1;
            state_reg <= IOBC_H_GAP;
          end
        end
        IOBC_H_GAP:
        begin
          bus.host_bus_oe <= req_data_phase_b_i;
          bus.host_bus <= 24'h000000;
          state_reg <= IOBC_H_PHB;
        end
        IOBC_H_PHB:
        begin
          bus.response_complete_strobe <= 1'b1;
          resp_word_o <= bus.bus_level;
          resp_valid_o <= 1'b1;
          state_reg <= IOBC_H_DONE;
        end
        default:
        begin
          bus.host_bus_oe <= 1'b0;
          state_reg <= IOBC_H_IDLE;
        end
      endcase
    end
  end
endmodule : iobc_host
`default_nettype wire

// ---- design/iobc_ctl.sv ----
// control end: decodes commands, answers phase b, buffers received data
`timescale 1ns/1ns
`default_nettype none
module iobc_ctl #(
  parameter logic [3:0] CHANNEL = 4'h3,
  parameter logic [5:0] CTL_ID = 6'h15, // arbitrary value
  parameter int DEPTH = iobc_pkg::FIFO_DEPTH
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  iobc_if.ctl bus,
  input wire logic [4:0] status_i,
  input wire logic read_reverse_i,
  input wire logic service_req_i,
  input wire logic [15:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [15:0] out_data_o,
  output logic terminate_o,
  output logic clear_o
);
  logic cmd_strobe;
  logic resp_strobe;
  logic [23:0] bus_word;
  iobc_pkg::iobc_cmd_t cmd_reg;
  logic pending_reg;
  logic fifo_in_valid;
  iobc_pkg::iobc_cmd_t dec;
  logic [23:0] status_word;
  // same-clock strobes read directly, so the answer stands before phase b
  assign cmd_strobe = bus.command_active_strobe;
  assign resp_strobe = bus.response_complete_strobe;
  assign bus_word = bus.bus_level;
  assign dec = iobc_pkg::iobc_decode(bus_word);
  always_comb
  begin
    status_word = 24'h000000;
    status_word[iobc_pkg::STAT_LO+4:iobc_pkg::STAT_LO] = status_i;
    status_word[iobc_pkg::REVERSE_BIT] = read_reverse_i;
  end
  assign fifo_in_valid = clk_en_i && cmd_strobe && dec == iobc_pkg::IOBC_XOUT_A
    && bus_word[iobc_pkg::CHAN_HI:iobc_pkg::CHAN_LO] == CHANNEL;
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      cmd_reg <= iobc_pkg::IOBC_NONE;
      pending_reg <= 1'b0;
      bus.ctl_bus <= 24'h000000;
      bus.ctl_bus_oe <= 1'b0;
      terminate_o <= 1'b0;
      clear_o <= 1'b0;
    end
    else if (clk_en_i)
    begin
      terminate_o <= 1'b0;
      clear_o <= 1'b0;
      if (cmd_strobe)
      begin
        if (dec == iobc_pkg::IOBC_SERVICE
          || bus_word[iobc_pkg::CHAN_HI:iobc_pkg::CHAN_LO] == CHANNEL)
        begin
          cmd_reg <= dec;
          pending_reg <= (dec != iobc_pkg::IOBC_NONE);
          terminate_o <= (dec == iobc_pkg::IOBC_TERM);
          bus.ctl_bus_oe <= !(dec == iobc_pkg::IOBC_NONE || dec == iobc_pkg::IOBC_XOUT_B
            || dec == iobc_pkg::IOBC_TERM || (dec == iobc_pkg::IOBC_SERVICE && !service_req_i));
          case (dec)
            iobc_pkg::IOBC_SERVICE: bus.ctl_bus <= 24'h000001 << CHANNEL;
            iobc_pkg::IOBC_XIN: bus.ctl_bus <= status_word | {8'h00, in_data_i};
            iobc_pkg::IOBC_TEST, iobc_pkg::IOBC_CLEAR:
              bus.ctl_bus <= status_word | {17'h00000, CTL_ID, 1'b0};
            default: bus.ctl_bus <= status_word;
          endcase
        end
        else
        begin
          pending_reg <= 1'b0;
          bus.ctl_bus_oe <= 1'b0;
        end
      end
      else if (resp_strobe && pending_reg)
      begin
        bus.ctl_bus_oe <= 1'b0;
        pending_reg <= 1'b0;
        clear_o <= (cmd_reg == iobc_pkg::IOBC_CLEAR);
      end
    end
  end
  iobc_fifo #(.WIDTH(16), .DEPTH(DEPTH)) u_fifo (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .clk_en_i(clk_en_i),
    .in_valid_i(fifo_in_valid),
    .in_ready_o(),
    .in_data_i(bus_word[iobc_pkg::DATA_HI:0]),
    .out_valid_o(out_valid_o),
    .out_ready_i(out_ready_i),
    .out_data_o(out_data_o)
  );
endmodule : iobc_ctl
`default_nettype wire

// ---- verification/iobc_props.sv ----
// concurrent checks on the bus joining processor end and control end
`timescale 1ns/1ns
`default_nettype none
module iobc_props #(
  parameter logic [3:0] CHANNEL = 4'h3
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic command_active_strobe,
  input wire logic response_complete_strobe,
  input wire logic [23:0] host_bus,
  input wire logic host_bus_oe,
  input wire logic [23:0] ctl_bus,
  input wire logic ctl_bus_oe,
  input wire logic [23:0] bus_level
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!reset_n_i);
  AST_CA_PULSE: assert property (command_active_strobe |=> !command_active_strobe)
    else $error("command strobe longer than one clock");
  AST_RC_PULSE: assert property (response_complete_strobe |=> !response_complete_strobe)
    else $error("response strobe longer than one clock");
  AST_B_FOLLOWS_A: assert property (command_active_strobe |-> ##2 response_complete_strobe)
    else $error("phase b did not follow phase a");
  AST_NO_OVERLAP: assert property (command_active_strobe |=> (!command_active_strobe)[*3])
    else $error("new command before response");
  AST_RC_HAS_CA: assert property (response_complete_strobe |-> $past(command_active_strobe, 2))
    else $error("response strobe without command");
  AST_HOST_DRIVES: assert property (command_active_strobe |-> host_bus_oe)
    else $error("host not driving with command strobe");
  AST_CMD_WITH_WORD: assert property ($rose(host_bus_oe) |-> command_active_strobe)
    else $error("host drove a word without command strobe");
  AST_OE_AFTER_CA: assert property ($rose(ctl_bus_oe) |-> $past(command_active_strobe))
    else $error("control drove bus outside phase b");
  AST_OE_RELEASE: assert property (response_complete_strobe |-> ##[1:5] !ctl_bus_oe)
    else $error("control kept bus after response");
  AST_OWN_ANSWER: assert property (command_active_strobe && host_bus[19:16] == CHANNEL
    && host_bus[23:20] != 4'h1 && host_bus[23:20] != 4'h3 |-> ##1 ctl_bus_oe)
    else $error("addressed control gave no answer");
  AST_OTHER_IGNORED: assert property (command_active_strobe && host_bus[19:16] != CHANNEL
    && host_bus[23:20] != 4'h1 |-> ##1 !ctl_bus_oe)
    else $error("unaddressed control answered");
  AST_LEVEL: assert property (ctl_bus_oe |-> !host_bus_oe)
    else $error("control and host drove the bus together");
endmodule : iobc_props
`default_nettype wire

// ---- verification/test_io_bus_command_cycles.sv ----
// self-checking bench joining processor end and control end
`timescale 1ns/1ns
`default_nettype none
module test_io_bus_command_cycles;
  logic clk, rst_n, rq_v, rq_rdy, rs_v, o_v, o_rdy, term, clr, rr, svc, seen;
  logic [23:0] rq_w, rs_w, got;
  logic [4:0] st;
  logic [15:0] din, o_d;
  int err_total, n_compared, n_term, n_clr, n;
  iobc_if i_iobc_if();
  iobc_host i_iobc_host (.core_clk_i(clk), .reset_n_i(rst_n), .clk_en_i(1'b1), .bus(i_iobc_if),
    .req_valid_i(rq_v), .req_ready_o(rq_rdy), .req_word_i(rq_w), .req_data_phase_b_i(1'b0),
    .resp_valid_o(rs_v), .resp_word_o(rs_w));
  iobc_ctl #(.CHANNEL(4'h3)) i_iobc_ctl (.core_clk_i(clk), .reset_n_i(rst_n), .clk_en_i(1'b1),
    .bus(i_iobc_if), .status_i(st), .read_reverse_i(rr), .service_req_i(svc), .in_data_i(din),
    .out_valid_o(o_v), .out_ready_i(o_rdy), .out_data_o(o_d), .terminate_o(term), .clear_o(clr));
  iobc_props #(.CHANNEL(4'h3)) i_iobc_props (.core_clk_i(clk), .reset_n_i(rst_n),
    .command_active_strobe(i_iobc_if.command_active_strobe),
    .response_complete_strobe(i_iobc_if.response_complete_strobe),
    .host_bus(i_iobc_if.host_bus), .host_bus_oe(i_iobc_if.host_bus_oe),
    .ctl_bus(i_iobc_if.ctl_bus), .ctl_bus_oe(i_iobc_if.ctl_bus_oe),
    .bus_level(i_iobc_if.bus_level));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk)
  begin
    if (term === 1'b1)
      n_term++;
    if (clr === 1'b1)
      n_clr++;
  end
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] act);
    n_compared++;
    if (act !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, act);
    end
  endtask : chk
  // one full two-phase cycle, keeps the word the control answered with
  task automatic cyc(input logic [23:0] w);
    int k;
    @(negedge clk);
    rq_w = w;
    rq_v = 1'b1;
    k = 0;
    while (rq_rdy !== 1'b1 && k < 20)
    begin
      @(negedge clk);
      k++;
    end
    rq_v = 1'b0;
    seen = 1'b0;
    got = 24'h000000;
    for (k = 0; k < 12 && rs_v !== 1'b1; k++)
    begin
      @(negedge clk);
      if (i_iobc_if.ctl_bus_oe === 1'b1)
        seen = 1'b1;
    end
    got = rs_w;
    repeat (8) @(negedge clk);
  endtask : cyc
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results
  initial
  begin
    #100000;
    err_total++;
    results();
  end
  initial
  begin
    {rst_n, rq_v, o_rdy, err_total, n_compared, n_term, n_clr} = '0;
    {rq_w, st, din, rr, svc} = {24'h000000, 5'h0b, 16'h5a3c, 1'b1, 1'b1};
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    cyc(24'h231234);
    chk("xout_a status", {18'h0, rr, st}, {18'h0, got[21:16]});
    rr = 1'b0;
    cyc(24'h430000);
    chk("xin data", {2'h0, rr, st, din}, {2'h0, got[21:0]});
    cyc(24'h130001);
    chk("test id", {12'h0, rr, st, 6'h15}, {12'h0, got[21:16], got[6:1]});
    cyc(24'h130003);
    chk("clear id", {12'h0, rr, st, 6'h15}, {12'h0, got[21:16], got[6:1]});
    chk("clear pulses", 24'h000001, n_clr[23:0]);
    cyc(24'h100005);
    chk("service mask", 24'h000008, {8'h0, got[15:0]});
    cyc(24'h130006);
    chk("terminate pulses", 24'h000001, n_term[23:0]);
    cyc(24'h25beef);
    chk("other channel", 24'h000000, {23'h0, seen});
    chk("other channel word", 24'h000000, got);
    cyc(24'h330000);
    chk("xout_b answer", 24'h000000, {23'h0, seen});
    for (int i = 1; i <= 32; i++)
      cyc({8'h23, i[15:0]});
    @(negedge clk);
    o_rdy = 1'b1;
    n = 0;
    for (int k = 0; k < 40; k++)
    begin
      if (o_v === 1'b1)
      begin
        chk("fifo word", {8'h0, (n == 0) ? 16'h1234 : n[15:0]}, {8'h0, o_d});
        n++;
      end
      @(negedge clk);
    end
    chk("fifo count", 24'd32, n[23:0]);
    results();
  end
endmodule : test_io_bus_command_cycles
`default_nettype wire
